// [design/bso_consts.vh]
// Constants of the bit, shift and flag execution slice
`ifndef BSO_CONSTS_VH
`define BSO_CONSTS_VH
// Register byte addresses
`define BSO_A_CMD 8'h00
`define BSO_A_DATA 8'h04
`define BSO_A_FLAGS 8'h08
`define BSO_A_PC 8'h0c
`define BSO_A_STAT 8'h10
`define BSO_A_IO0 8'h20
`define BSO_A_IOMASK 8'he0
`define BSO_IO_LSB 2
`define BSO_IO_MSB 4
// Command word fields
`define BSO_OP_LSB 0
`define BSO_OP_MSB 4
`define BSO_BIT_LSB 8
`define BSO_BIT_MSB 10
`define BSO_IOA_LSB 12
`define BSO_IOA_MSB 14
`define BSO_K_LSB 16
`define BSO_K_MSB 22
// Operation codes
`define BSO_OP_BR_ISET 5'h01
`define BSO_OP_BR_ICLR 5'h02
`define BSO_OP_IOSET 5'h03
`define BSO_OP_IOCLR 5'h04
`define BSO_OP_SHL 5'h05
`define BSO_OP_SHR 5'h06
`define BSO_OP_RCL 5'h07
`define BSO_OP_RCR 5'h08
`define BSO_OP_SAR 5'h09
`define BSO_OP_SWAP 5'h0a
`define BSO_OP_FSET 5'h0b
`define BSO_OP_FCLR 5'h0c
`define BSO_OP_TSTO 5'h0d
`define BSO_OP_TLOD 5'h0e
`define BSO_OP_CSET 5'h0f
`define BSO_OP_CCLR 5'h10
// Flag positions in flags_reg
`define BSO_F_C 0
`define BSO_F_Z 1
`define BSO_F_N 2
`define BSO_F_V 3
`define BSO_F_T 6
`define BSO_F_I 7
// Reset values and cycle figures
`define BSO_RST_8 8'h00
`define BSO_RST_PC 16'h0000
`define BSO_PC_STEP 16'h0001
`define BSO_CYC_1 2'h1
`define BSO_CYC_2 2'h2
`define BSO_RESP_OK 2'h0
`define BSO_RESP_ERR 2'h2
`endif

// [design/bso_exec.v]
// Bit, shift and flag execution slice with an AXI4-Lite register port
`timescale 1ns/1ps
`include "bso_consts.vh"
`default_nettype none
module bso_exec (
	input wire ref_clk,
	input wire rst_n,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire irq_req,
	output reg irq_ack,
	output wire op_busy
);
	localparam ST_IDLE = 2'h0;
	localparam ST_IO2 = 2'h1;
	localparam ST_BR2 = 2'h2;

	// ****************************************
	// Write channel capture
	// ****************************************
	reg aw_full_reg;
	reg w_full_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire aw_have = aw_full_reg | aw_take;
	wire w_have = w_full_reg | w_take;
	wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
	wire [7:0] wa = aw_full_reg ? aw_addr_reg : s_axi_awaddr;
	wire [31:0] wd = w_full_reg ? w_data_reg : s_axi_wdata;
	wire [3:0] ws = w_full_reg ? w_strb_reg : s_axi_wstrb;
	assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;

	// Hold whichever half arrives first until the other joins it
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= `BSO_RST_8;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
		end else begin
			if (wr_fire) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
			end else begin
				if (aw_take) begin
					aw_full_reg <= 1'b1;
					aw_addr_reg <= s_axi_awaddr;
				end
				if (w_take) begin
					w_full_reg <= 1'b1;
					w_data_reg <= s_axi_wdata;
					w_strb_reg <= s_axi_wstrb;
				end
			end
		end
	end

	// ****************************************
	// Architectural state
	// ****************************************
	reg [7:0] data_reg;
	reg [7:0] flags_reg;
	reg [15:0] pc_reg;
	reg [1:0] state_reg;
	reg [1:0] last_cyc_reg;
	reg [7:0] tmp_reg;
	reg [4:0] lat_op_reg;
	reg [2:0] lat_bit_reg;
	reg [2:0] lat_ioa_reg;
	reg [6:0] lat_k_reg;
	reg [7:0] io_mem [0:7];
	integer i;

	wire is_io = (wa & `BSO_A_IOMASK) == `BSO_A_IO0;
	wire idle = state_reg == ST_IDLE;
	// Status word is read-only, so a write to it is refused like an unmapped one
	wire mapped = is_io | wa == `BSO_A_CMD | wa == `BSO_A_DATA | wa == `BSO_A_FLAGS |
		wa == `BSO_A_PC;
	// Busy slice refuses every write so a two-cycle operation is never disturbed
	wire wr_ok = wr_fire & idle & mapped;
	wire cmd_go = wr_ok & wa == `BSO_A_CMD;
	wire [4:0] c_op = wd[`BSO_OP_MSB:`BSO_OP_LSB];
	wire [2:0] c_bit = wd[`BSO_BIT_MSB:`BSO_BIT_LSB];
	wire [2:0] c_ioa = wd[`BSO_IOA_MSB:`BSO_IOA_LSB];
	wire [6:0] c_k = wd[`BSO_K_MSB:`BSO_K_LSB];
	wire [2:0] w_ioa = wa[`BSO_IO_MSB:`BSO_IO_LSB];
	wire [7:0] c_mask = 8'h01 << c_bit;
	wire [7:0] l_mask = 8'h01 << lat_bit_reg;
	wire [15:0] pc_inc = pc_reg + `BSO_PC_STEP;
	wire [15:0] pc_br = pc_reg + {{9{lat_k_reg[6]}}, lat_k_reg} + `BSO_PC_STEP;
	wire i_flag = flags_reg[`BSO_F_I];
	assign op_busy = ~idle;

	// Shift unit result and carry out
	reg [7:0] sh_res;
	reg sh_c;
	always @* begin
		sh_res = data_reg;
		sh_c = flags_reg[`BSO_F_C];
		case (c_op)
			`BSO_OP_SHL: begin
				sh_res = {data_reg[6:0], 1'b0};
				sh_c = data_reg[7];
			end
			`BSO_OP_SHR: begin
				sh_res = {1'b0, data_reg[7:1]};
				sh_c = data_reg[0];
			end
			`BSO_OP_RCL: begin
				sh_res = {data_reg[6:0], flags_reg[`BSO_F_C]};
				sh_c = data_reg[7];
			end
			`BSO_OP_RCR: begin
				sh_res = {flags_reg[`BSO_F_C], data_reg[7:1]};
				sh_c = data_reg[0];
			end
			`BSO_OP_SAR: begin
				sh_res = {data_reg[7], data_reg[7:1]};
				sh_c = data_reg[0];
			end
			default: begin
				sh_res = data_reg;
				sh_c = flags_reg[`BSO_F_C];
			end
		endcase
	end

	// Flags after a shift: overflow is negative xor carry
	wire [7:0] sh_flags = {flags_reg[7:4], sh_res[7] ^ sh_c, sh_res[7], sh_res == `BSO_RST_8, sh_c};
	wire is_shift = c_op == `BSO_OP_SHL | c_op == `BSO_OP_SHR | c_op == `BSO_OP_RCL |
		c_op == `BSO_OP_RCR | c_op == `BSO_OP_SAR;

	// ****************************************
	// Execution and register writes
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			data_reg <= `BSO_RST_8;
			flags_reg <= `BSO_RST_8;
			pc_reg <= `BSO_RST_PC;
			state_reg <= ST_IDLE;
			last_cyc_reg <= 2'h0;
			tmp_reg <= `BSO_RST_8;
			lat_op_reg <= 5'h00;
			lat_bit_reg <= 3'h0;
			lat_ioa_reg <= 3'h0;
			lat_k_reg <= 7'h00;
			irq_ack <= 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				io_mem[i] <= `BSO_RST_8;
			end
		end else begin
			irq_ack <= 1'b0;
			if (cmd_go) begin
				lat_op_reg <= c_op;
				lat_bit_reg <= c_bit;
				lat_ioa_reg <= c_ioa;
				lat_k_reg <= c_k;
				last_cyc_reg <= `BSO_CYC_1;
				pc_reg <= pc_inc;
				if (is_shift) begin
					data_reg <= sh_res;
					flags_reg <= sh_flags;
				end
				case (c_op)
					`BSO_OP_BR_ISET, `BSO_OP_BR_ICLR: begin
						// Taken branch spends a second cycle forming the target
						if (i_flag == (c_op == `BSO_OP_BR_ISET)) begin
							state_reg <= ST_BR2;
							pc_reg <= pc_reg;
						end
					end
					`BSO_OP_IOSET, `BSO_OP_IOCLR: begin
						tmp_reg <= io_mem[c_ioa];
						state_reg <= ST_IO2;
						pc_reg <= pc_reg;
					end
					`BSO_OP_SWAP: data_reg <= {data_reg[3:0], data_reg[7:4]};
					`BSO_OP_FSET: flags_reg <= flags_reg | c_mask;
					`BSO_OP_FCLR: flags_reg <= flags_reg & ~c_mask;
					`BSO_OP_TSTO: flags_reg[`BSO_F_T] <= data_reg[c_bit];
					`BSO_OP_TLOD: data_reg[c_bit] <= flags_reg[`BSO_F_T];
					`BSO_OP_CSET: flags_reg[`BSO_F_C] <= 1'b1;
					`BSO_OP_CCLR: flags_reg[`BSO_F_C] <= 1'b0;
					default: state_reg <= ST_IDLE;
				endcase
			end else if (state_reg == ST_IO2) begin
				// Write back only the chosen bit of the value read one cycle earlier
				if (lat_op_reg == `BSO_OP_IOSET) begin
					io_mem[lat_ioa_reg] <= tmp_reg | l_mask;
				end else begin
					io_mem[lat_ioa_reg] <= tmp_reg & ~l_mask;
				end
				pc_reg <= pc_inc;
				last_cyc_reg <= `BSO_CYC_2;
				state_reg <= ST_IDLE;
			end else if (state_reg == ST_BR2) begin
				pc_reg <= pc_br;
				last_cyc_reg <= `BSO_CYC_2;
				state_reg <= ST_IDLE;
			end else if (wr_ok) begin
				// Plain register writes, low byte lane only, except byte lanes 0 and 1 for the program counter
				if (wa == `BSO_A_DATA && ws[0]) begin
					data_reg <= wd[7:0];
				end
				if (wa == `BSO_A_FLAGS && ws[0]) begin
					flags_reg <= wd[7:0];
				end
				if (wa == `BSO_A_PC) begin
					if (ws[0]) begin
						pc_reg[7:0] <= wd[7:0];
					end
					if (ws[1]) begin
						pc_reg[15:8] <= wd[15:8];
					end
				end
				if (is_io && ws[0]) begin
					io_mem[w_ioa] <= wd[7:0];
				end
			end
			// Interrupts wait while an operation is in flight or starting
			if (irq_req && i_flag && idle && !cmd_go && !wr_ok) begin
				irq_ack <= 1'b1;
				flags_reg[`BSO_F_I] <= 1'b0;
			end
		end
	end

	// ****************************************
	// Write response
	// ****************************************
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BSO_RESP_OK;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `BSO_RESP_OK : `BSO_RESP_ERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	assign s_axi_arready = ~s_axi_rvalid;
	wire [7:0] ra = s_axi_araddr;
	wire ra_io = (ra & `BSO_A_IOMASK) == `BSO_A_IO0;
	reg [31:0] rd_mux;
	reg rd_hit;
	always @* begin
		rd_mux = 32'h00000000;
		rd_hit = 1'b1;
		if (ra_io) begin
			rd_mux = {24'h000000, io_mem[ra[`BSO_IO_MSB:`BSO_IO_LSB]]};
		end else begin
			case (ra)
				`BSO_A_CMD: rd_mux = {9'h000, lat_k_reg, 1'b0, lat_ioa_reg, 1'b0, lat_bit_reg,
					3'h0, lat_op_reg};
				`BSO_A_DATA: rd_mux = {24'h000000, data_reg};
				`BSO_A_FLAGS: rd_mux = {24'h000000, flags_reg};
				`BSO_A_PC: rd_mux = {16'h0000, pc_reg};
				`BSO_A_STAT: rd_mux = {28'h0000000, last_cyc_reg, state_reg == ST_BR2, op_busy};
				default: begin
					rd_mux = 32'h00000000;
					rd_hit = 1'b0;
				end
			endcase
		end
	end

	// Read data registered; unmapped addresses answer with an error
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `BSO_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? `BSO_RESP_OK : `BSO_RESP_ERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // bso_exec
`default_nettype wire

// [verif/bit_shift_flag_ops_tb_top.sv]
// Self-checking testbench for the bit, shift and flag execution slice
`timescale 1ns/1ps
`include "bso_consts.vh"
`default_nettype none
module bit_shift_flag_ops_tb_top;
	logic ref_clk = 0, rst_n = 0, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0, irq = 0;
	logic [7:0] awa = 0, ara = 0, d, f, x;
	logic [31:0] wd = 0, g;
	logic [1:0] r;
	logic [15:0] p, q, e;
	logic [4:0] op;
	logic [2:0] b, n;
	logic [6:0] k;
	logic t;
	wire awr, wr, bv, arr, rv, ack, busy;
	wire [1:0] br, rr;
	wire [31:0] rdt;
	integer fails = 0, check_count = 0, acks = 0, i;
	bso_exec bso_exec_i (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd),
		.irq_req(irq), .irq_ack(ack), .op_busy(busy));
	// 125 MHz clock
	initial forever #4 ref_clk = ~ref_clk;
	// Count taken interrupts; the pulse lasts one cycle
	always @(posedge ref_clk) if (ack) acks++;
	// Write: offer both channels, release each once taken
	task axw(input [7:0] a, input [31:0] v);
		logic ta, tw, dn;
		begin
			@(posedge ref_clk);
			awa <= a;
			wd <= v;
			awv <= 1'b1;
			wv <= 1'b1;
			brd <= 1'b1;
			dn = 0;
			while (!dn) begin
				@(negedge ref_clk);
				ta = awr;
				tw = wr;
				dn = bv;
				r = br;
				@(posedge ref_clk);
				if (ta) awv <= 1'b0;
				if (tw) wv <= 1'b0;
				if (dn) brd <= 1'b0;
			end
		end
	endtask
	// Read: result lands in g and r
	task axr(input [7:0] a);
		logic ta, dn;
		begin
			@(posedge ref_clk);
			ara <= a;
			arv <= 1'b1;
			rrd <= 1'b1;
			dn = 0;
			while (!dn) begin
				@(negedge ref_clk);
				ta = arr;
				dn = rv;
				g = rdt;
				r = rr;
				@(posedge ref_clk);
				if (ta) arv <= 1'b0;
				if (dn) rrd <= 1'b0;
			end
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			check_count++;
			if (got !== exp) begin
				fails++;
				$display("CHECK FAILED at %0t: value %h expected %h", $time, got, exp);
			end
		end
	endtask
	task chkr(input [1:0] got, input [1:0] exp);
		begin
			check_count++;
			if (got !== exp) begin
				fails++;
				$display("CHECK FAILED at %0t: response %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rdc(input [7:0] a, input [31:0] exp);
		begin
			axr(a);
			chk(g, exp);
		end
	endtask
	// Expected {data, flags}; shifts set V as N xor C
	function automatic [15:0] ref_op(input [4:0] o, input [2:0] s, input [7:0] v, input [7:0] fl);
		logic [7:0] y, z;
		logic c;
		begin
			y = v; z = fl; c = fl[`BSO_F_C];
			case (o)
				`BSO_OP_SHL: {c, y} = {v, 1'b0};
				`BSO_OP_SHR: {y, c} = {1'b0, v};
				`BSO_OP_RCL: {c, y} = {v, fl[`BSO_F_C]};
				`BSO_OP_RCR: {y, c} = {fl[`BSO_F_C], v};
				`BSO_OP_SAR: {y, c} = {v[7], v};
				`BSO_OP_SWAP: y = {v[3:0], v[7:4]};
				`BSO_OP_FSET: z[s] = 1'b1;
				`BSO_OP_FCLR: z[s] = 1'b0;
				`BSO_OP_TSTO: z[`BSO_F_T] = v[s];
				`BSO_OP_TLOD: y[s] = fl[`BSO_F_T];
				`BSO_OP_CSET: z[`BSO_F_C] = 1'b1;
				`BSO_OP_CCLR: z[`BSO_F_C] = 1'b0;
				default: ;
			endcase
			if (o >= `BSO_OP_SHL && o <= `BSO_OP_SAR)
				z[3:0] = {y[7] ^ c, y[7], y == 8'h0, c};
			ref_op = {y, z};
		end
	endfunction
	task complete_run;
		begin
			$display("Comparisons %0d, mismatches %0d", check_count, fails);
			if (fails == 0 && check_count > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		#400000;
		fails++;
		complete_run;
	end
	// ****************
	// Tests
	// ****************
	initial begin
		g = $urandom(81835);
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdc(`BSO_A_FLAGS, 0);
		rdc(`BSO_A_PC, 0);
		rdc(8'h14, 0);
		chkr(r, `BSO_RESP_ERR);
		axw(`BSO_A_STAT, 0);
		chkr(r, `BSO_RESP_ERR);
		$display("reset and unmapped test done");
		// Shift codes up to one unused code, which must only step the program counter
		for (i = 0; i < 96; i++) begin
			op = `BSO_OP_SHL + i % 13;
			d = $urandom;
			f = $urandom & 8'h7f;
			b = $urandom;
			p = $urandom;
			axw(`BSO_A_DATA, d);
			axw(`BSO_A_FLAGS, f);
			axw(`BSO_A_PC, p);
			axw(`BSO_A_CMD, {21'h0, b, 3'h0, op});
			e = ref_op(op, b, d, f);
			q = p + 16'h1;
			rdc(`BSO_A_DATA, e[15:8]);
			rdc(`BSO_A_FLAGS, e[7:0]);
			rdc(`BSO_A_PC, q);
			axr(`BSO_A_STAT);
			chk(g[3:2], `BSO_CYC_1);
		end
		$display("single-cycle op test done");
		for (i = 0; i < 16; i++) begin
			op = `BSO_OP_BR_ISET + i[0];
			t = i[1];
			p = $urandom;
			k = (i == 1) ? 7'h40 : (i == 2) ? 7'h3f : $urandom;
			axw(`BSO_A_FLAGS, {t, 7'h0});
			axw(`BSO_A_PC, p);
			axw(`BSO_A_CMD, {9'h0, k, 11'h0, op});
			e = ((op == `BSO_OP_BR_ISET) == t) ? 16'h2 : 16'h1;
			q = p + 16'h1 + (e[1] ? {{9{k[6]}}, k} : 16'h0);
			rdc(`BSO_A_PC, q);
			axr(`BSO_A_STAT);
			chk(g[3:2], e[1:0]);
			// The command word reads back the fields that were latched
			rdc(`BSO_A_CMD, {9'h0, k, 11'h0, op});
		end
		$display("branch test done");
		for (i = 0; i < 16; i++) begin
			op = `BSO_OP_IOSET + i[0];
			n = $urandom;
			b = $urandom;
			d = $urandom;
			f = $urandom;
			f[`BSO_F_I] = (i == 15);
			axw(`BSO_A_IO0 + {n, 2'b00}, d);
			axw(`BSO_A_FLAGS, f);
			// The last pass raises a request right as the two-cycle op starts
			fork
				axw(`BSO_A_CMD, {17'h0, n, 1'b0, b, 3'h0, op});
				begin
					@(posedge ref_clk);
					irq <= (i == 15);
				end
			join
			x = i[0] ? d & ~(8'h1 << b) : d | (8'h1 << b);
			rdc(`BSO_A_IO0 + {n, 2'b00}, x);
			x = f & 8'h7f;
			rdc(`BSO_A_FLAGS, x);
			axr(`BSO_A_STAT);
			chk(g[3:2], `BSO_CYC_2);
		end
		irq <= 1'b0;
		chk(acks, 1);
		$display("I/O bit and interrupt test done");
		complete_run;
	end
endmodule // bit_shift_flag_ops_tb_top
`default_nettype wire

// [verif/bso_exec_chk.sv]
// Port-level assertions for the bit, shift and flag execution slice
`timescale 1ns/1ps
`default_nettype none
module bso_exec_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic irq_req,
	input wire logic irq_ack,
	input wire logic op_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Steps of a command: taken write, then the second cycle of a long op
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence busy_start;
		$rose(op_busy);
	endsequence
	sequence busy_end;
		$fell(op_busy);
	endsequence
	AST_BUSY_ONE: assert property (busy_start |=> !op_busy)
		else $error("second cycle of a long op lasted more than one cycle");
	AST_BUSY_AFTER_CMD: assert property (busy_start |-> $rose(s_axi_bvalid))
		else $error("long op started without a command write");
	AST_BUSY_NO_ACK: assert property (op_busy |-> !irq_ack)
		else $error("interrupt taken inside a long op");
	AST_ACK_NOT_CMD: assert property ($rose(s_axi_bvalid) && s_axi_bresp == 2'h0 |-> !irq_ack)
		else $error("interrupt taken at a command edge");
	AST_END_NO_ACK: assert property (busy_end |-> !irq_ack)
		else $error("interrupt taken in the last cycle of a long op");
	AST_ACK_PULSE: assert property (irq_ack |=> !irq_ack)
		else $error("interrupt acknowledge longer than one cycle");
	AST_ACK_CAUSE: assert property (irq_ack |-> $past(irq_req))
		else $error("interrupt acknowledge without request");
	AST_WR_RESP: assert property (wr_take |=> s_axi_bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
	AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
endmodule // bso_exec_chk
bind bso_exec bso_exec_chk bso_exec_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .irq_req(irq_req), .irq_ack(irq_ack), .op_busy(op_busy));
`default_nettype wire
